// ---- sim/hsp_host_model.sv ----
`timescale 1ns/100ps
module hsp_host_model
(
    // Serial pins toward the device
    output logic chip_select_n_out,
    output logic serial_clk_out,
    output logic host_to_device_line_out,
    // Read line from the device
    input wire logic reply_data_in,
    input wire logic reply_data_oe_n_in
);
    logic idle_bit;
    // A released read line keeps changing, so a stale bit never passes
    wire logic line_seen = reply_data_oe_n_in ? idle_bit : reply_data_in;

    initial
    begin
        chip_select_n_out = 1'b1;
        serial_clk_out = 1'b0;
        host_to_device_line_out = 1'b0;
        idle_bit = 1'b0;
    end

    always #5 idle_bit = ~idle_bit;

    // Sends nbits MSB first, pausing gap_ns after each byte
    task automatic xfer(input logic [23:0] bits, input int nbits, input bit idle_hi,
                        input int gap_ns, output logic [23:0] rx);
        rx = 24'h0;
        serial_clk_out = idle_hi;
        #40;
        chip_select_n_out = 1'b0;
        #40;
        for (int i = 0; i < nbits; i++)
        begin
            serial_clk_out = 1'b0;
            host_to_device_line_out = bits[23 - i];
            #32;
            serial_clk_out = 1'b1;
            #30;
            rx = {rx[22:0], line_seen};
            #2;
            if (i % 8 == 7)
                #(gap_ns);
        end
        if (!idle_hi)
            serial_clk_out = 1'b0;
        #40;
        chip_select_n_out = 1'b1;
        host_to_device_line_out = ~host_to_device_line_out;
        #40;
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench
    import hsp_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
        logic [1:0] nb;
        logic idle_hi;
        logic [9:0] gap;
        logic rd;
        logic [23:0] exp;
    } hsp_row_t;

    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_ready = 1'b1;
    logic prg_ready = 1'b1;
    logic [14:1] status_set = 14'h0000;
    wire logic chip_select_n;
    wire logic sclk;
    wire logic mosi;
    logic reply, reply_oe_n, irq_n, irq_oe_n, wr_valid, rd_strobe, gen_rst;
    hsp_wr_t wr_word;
    logic [7:0] rd_addr;
    logic [15:0] rd_word;
    logic [23:0] rx;
    logic oe_seen = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int resets_seen = 0;
    hsp_wr_t wr_q[$];
    hsp_row_t rows[8] = '{
        '{8'h10, 16'h00A5, 2'd1, 1'b0, 10'd0, 1'b0, 24'h1000A5},
        '{8'h9F, 16'h003C, 2'd1, 1'b1, 10'd500, 1'b0, 24'h9F003C},
        '{8'hE0, 16'h1234, 2'd2, 1'b1, 10'd0, 1'b0, 24'hE01234},
        '{8'hA0, 16'hBEEF, 2'd2, 1'b0, 10'd300, 1'b0, 24'hA0BEEF},
        '{8'hFF, 16'h8001, 2'd2, 1'b0, 10'd0, 1'b0, 24'hFF8001},
        '{8'hC5, 16'h0000, 2'd2, 1'b0, 10'd0, 1'b1, 24'h00C53A},
        '{8'hB9, 16'h0000, 2'd2, 1'b1, 10'd200, 1'b1, 24'h00B946},
        '{8'hA9, 16'h0000, 2'd2, 1'b0, 10'd0, 1'b1, 24'h00A956}};

    always #4 clk_in = ~clk_in;

    // Core answers with a word derived from the address
    assign rd_word = {rd_addr, ~rd_addr};

    hsp_port #(.LATENCY_CYCLES(16)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .chip_select_n_in(chip_select_n), .serial_clk_in(sclk),
        .host_to_device_line_in(mosi), .reply_data_out(reply),
        .reply_data_oe_n_out(reply_oe_n), .interrupt_request_n_out(irq_n),
        .interrupt_request_oe_n_out(irq_oe_n), .wr_valid_out(wr_valid),
        .wr_word_out(wr_word), .wr_ready_in(wr_ready), .rd_addr_out(rd_addr),
        .rd_strobe_out(rd_strobe), .rd_word_in(rd_word), .status_set_in(status_set),
        .prg_ready_in(prg_ready), .general_reset_out(gen_rst));

    hsp_host_model host (.chip_select_n_out(chip_select_n), .serial_clk_out(sclk),
        .host_to_device_line_out(mosi), .reply_data_in(reply),
        .reply_data_oe_n_in(reply_oe_n));

    always @(posedge clk_in)
    begin
        if (wr_valid && wr_ready)
            wr_q.push_back(wr_word);
        if (reply_oe_n === 1'b0)
            oe_seen = 1'b1;
        if (gen_rst === 1'b1)
            resets_seen++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic expect_wr(input logic [23:0] exp);
        for (int n = 0; n < 200 && wr_q.size() == 0; n++)
            step(1);
        if (wr_q.size() == 0)
        begin
            num_errors++;
            $display("MISMATCH write_word expected %h seen none", exp);
            results();
        end
        else
            check("write_word", wr_q.pop_front(), exp);
    endtask

    task automatic wait_irq(input logic level);
        for (int n = 0; n < 60 && irq_oe_n !== level; n++)
            step(1);
        check("irq_enable", {23'h0, irq_oe_n}, {23'h0, level});
    endtask

    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        step(10);
        check("reset_outputs", {20'h0, reply_oe_n, irq_oe_n, wr_valid, rd_strobe}, 24'hC);
        sys_rst_in = 1'b0;
        step(5);
        foreach (rows[i])
        begin
            oe_seen = 1'b0;
            host.xfer({rows[i].addr, rows[i].nb == 2'd1 ? {rows[i].data[7:0], 8'h00}
                : rows[i].data}, 8 + 8 * rows[i].nb, rows[i].idle_hi, rows[i].gap, rx);
            check("read_enable", {23'h0, oe_seen}, {23'h0, rows[i].rd});
            if (rows[i].rd)
            begin
                check("read_word", {8'h0, rx[15:0]}, rows[i].exp);
                check("read_addr", {16'h0, rd_addr}, {16'h0, rows[i].addr});
            end
            else
                expect_wr(rows[i].exp);
        end
        // Abandoned byte must leave nothing behind
        host.xfer({8'h40, 16'h0000}, 12, 1'b0, 0, rx);
        host.xfer({8'h11, 8'h77, 8'h00}, 16, 1'b0, 0, rx);
        expect_wr(24'h110077);
        // Stalled core: three words wait, none lost
        wr_ready = 1'b0;
        for (int k = 0; k < 3; k++)
            host.xfer({8'h20 + 8'(k), 8'h01 + 8'(k), 8'h00}, 16, 1'b0, 0, rx);
        step(10);
        check("stall_head", {wr_valid, wr_word[22:0]}, 24'h A00001);
        wr_ready = 1'b1;
        for (int k = 0; k < 3; k++)
            expect_wr({8'h20 + 8'(k), 8'h00, 8'h01 + 8'(k)});
        // Flag raised while masked, then unmasked
        status_set = 14'h0004;
        step(1);
        status_set = 14'h0000;
        step(20);
        check("irq_masked", {23'h0, irq_oe_n}, 24'h1);
        host.xfer({HSP_ADDR_MASK, 16'h8008}, 24, 1'b0, 0, rx);
        wait_irq(1'b0);
        check("irq_level", {23'h0, irq_n}, 24'h0);
        host.xfer({HSP_ADDR_STATUS, 16'h0000}, 24, 1'b0, 0, rx);
        check("status_first", {8'h0, rx[15:0]}, 24'h008009);
        check("irq_cleared", {23'h0, irq_oe_n}, 24'h1);
        host.xfer({HSP_ADDR_STATUS, 16'h0000}, 24, 1'b1, 0, rx);
        check("status_again", {8'h0, rx[15:0]}, 24'h000001);
        // Command byte only: reset pulse, no register write
        resets_seen = 0;
        host.xfer({HSP_CMD_RESET, 16'h0000}, 8, 1'b1, 0, rx);
        step(4);
        check("reset_pulses", 24'(resets_seen), 24'h1);
        check("no_write", 24'(wr_q.size()), 24'h0);
        results();
    end
endmodule

// ---- verilog/hsp_pair_buf.sv ----
`timescale 1ns/100ps
module hsp_pair_buf
    import hsp_pkg::*;
#(
    parameter int WIDTH = 24
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Filling side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic head_v;
        logic tail_v;
    } hsp_buf_state_t;

    hsp_buf_state_t q;
    hsp_buf_state_t d;

    // Ready comes from a flop: a full tail refuses, so no word is ever dropped
    always_comb
    begin
        d = q;
        if (out_ready_in && q.head_v)
        begin
            if (q.tail_v)
            begin
                d.head = q.tail;
                d.tail_v = 1'b0;
            end
            else
            begin
                d.head_v = 1'b0;
            end
        end
        if (in_valid_in && !q.tail_v)
        begin
            if (!d.head_v)
            begin
                d.head = in_data_in;
                d.head_v = 1'b1;
            end
            else
            begin
                d.tail = in_data_in;
                d.tail_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_ready_out = ~q.tail_v;
    assign out_valid_out = q.head_v;
    assign out_data_out = q.head;

    a_buf_full_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        q.tail_v && !out_ready_in |=> q.tail_v && q.head_v)
        else $error("buffer lost a held word");
endmodule

// ---- verilog/hsp_pkg.sv ----
// Overview of operation
// RL1: Each transaction is one address byte, optionally followed by data bytes.
// RL2: Number of data bytes is decided from the address byte value.
// RL3: Host data line is sampled on each rising serial clock edge.
// RL4: Read bits change on falling edges, so they hold while clock is high.
// RL5: Host holds chip select low during a transfer, high between transfers.
// RL6: Address and data bytes move most significant bit first.
// RL7: Host writes take effect at the next poll, up to 250 us later.
// RL8: Host should not write one register twice within 250 us.
// RL9: Command transfer is the address byte only; code 01 is general reset.
// RL10: Single-byte registers move exactly eight data bits after the address.
// RL11: Read line stays high impedance unless the address selects a read.
// RL12: Serial clock may rest high or low at transaction start and end.
// RL13: Any gap, or none, between bytes of a transaction is accepted.
// RL14: Interrupt flag is raised only for status changes whose mask bit is set.
// RL15: Status read clears all flags except programming ready, and the request.
// RL16: Interrupt pin is active while status bit 15 and mask bit 15 are set.
// RL17: Two-byte words move upper byte first, then lower byte.
// RL18: Chip select rising mid-byte abandons the transaction and resets bit count.
package hsp_pkg;

    localparam logic [7:0] HSP_CMD_RESET = 8'h01;
    localparam logic [7:0] HSP_CMD_LIMIT = 8'h10;
    localparam logic [7:0] HSP_SINGLE_LO = 8'h10;
    localparam logic [7:0] HSP_SINGLE_HI = 8'h9F;
    localparam logic [7:0] HSP_ADDR_STATUS = 8'hC6;
    localparam logic [7:0] HSP_ADDR_MASK = 8'hCE;
    localparam logic [7:0] HSP_ADDR_ID = 8'hC5;
    localparam logic [7:0] HSP_ADDR_VER = 8'hC9;
    localparam logic [7:0] HSP_ADDR_SUM0 = 8'hA9;
    localparam logic [7:0] HSP_ADDR_SUM1 = 8'hAA;
    localparam logic [7:0] HSP_ADDR_SUM2 = 8'hB8;
    localparam logic [7:0] HSP_ADDR_SUM3 = 8'hB9;
    localparam int HSP_IRQ_BIT = 15;
    localparam int HSP_PRG_BIT = 0;
    localparam logic [15:0] HSP_MASK_RST = 16'h0000;
    localparam logic [15:0] HSP_STATUS_RST = 16'h0000;
    localparam int HSP_LATENCY_US = 250;
    localparam int HSP_CLK_MHZ = 125;
    localparam int HSP_LATENCY_CYC = HSP_LATENCY_US * HSP_CLK_MHZ;

    typedef enum logic [2:0] {
        HSP_IDLE,
        HSP_ADDR,
        HSP_LOAD,
        HSP_WDATA,
        HSP_RDATA,
        HSP_DONE
    } hsp_phase_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } hsp_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } hsp_wr_t;

    typedef struct packed {
        hsp_pins_t pins1;
        hsp_pins_t pins2;
        logic sck_old;
        hsp_phase_t phase;
        logic [3:0] bitcnt;
        logic [1:0] nbytes;
        logic [7:0] addr;
        logic [15:0] shreg;
        logic [15:0] tx;
        logic miso;
        logic oe_n;
        logic pend_v;
        hsp_wr_t pend;
        logic [15:0] status;
        logic [14:0] en_old;
        logic [15:0] mask;
        logic [15:0] mask_new;
        logic mask_pend;
        logic [14:0] timer;
        logic [7:0] rd_addr;
        logic rd_strobe;
        logic gen_reset;
        logic irq_n;
    } hsp_state_t;

    function automatic logic hsp_is_read(input logic [7:0] a);
        return a inside {HSP_ADDR_STATUS, HSP_ADDR_ID, HSP_ADDR_VER, HSP_ADDR_SUM0,
                         HSP_ADDR_SUM1, HSP_ADDR_SUM2, HSP_ADDR_SUM3};
    endfunction

    function automatic logic [1:0] hsp_nbytes(input logic [7:0] a);
        return (a >= HSP_SINGLE_LO && a <= HSP_SINGLE_HI) ? 2'd1 : 2'd2;
    endfunction

endpackage

// ---- verilog/hsp_port.sv ----
`timescale 1ns/100ps
module hsp_port
    import hsp_pkg::*;
#(
    parameter int LATENCY_CYCLES = HSP_LATENCY_CYC
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial pins from the host
    input wire logic chip_select_n_in,
    input wire logic serial_clk_in,
    input wire logic host_to_device_line_in,
    // Serial read line, three-state
    output logic reply_data_out,
    output logic reply_data_oe_n_out,
    // Open-drain interrupt
    output logic interrupt_request_n_out,
    output logic interrupt_request_oe_n_out,
    // Register writes toward the core
    output logic wr_valid_out,
    output hsp_wr_t wr_word_out,
    input wire logic wr_ready_in,
    // Register reads from the core
    output logic [7:0] rd_addr_out,
    output logic rd_strobe_out,
    input wire logic [15:0] rd_word_in,
    // Core status and control
    input wire logic [14:1] status_set_in,
    input wire logic prg_ready_in,
    output logic general_reset_out
);
    hsp_state_t q;
    hsp_state_t d;
    logic buf_ready;
    logic cs_low;
    logic rise;
    logic fall;
    logic addr_done;
    logic [7:0] addr_byte;
    logic [14:0] newly;
    logic [15:0] wdata;

    // Only the second stage of each synchroniser is looked at
    assign cs_low = ~q.pins2.cs_n;
    assign rise = q.pins2.sclk & ~q.sck_old;
    assign fall = ~q.pins2.sclk & q.sck_old;
    assign addr_done = cs_low && rise && q.phase == HSP_ADDR && q.bitcnt == 4'd7;
    assign addr_byte = {q.shreg[6:0], q.pins2.mosi};
    assign newly = (q.status[14:0] & q.mask[14:0]) & ~q.en_old;
    assign wdata = (q.nbytes == 2'd1 && hsp_nbytes(q.addr) == 2'd1)
        ? {8'h00, q.shreg[6:0], q.pins2.mosi} : {q.shreg[14:0], q.pins2.mosi};

    always_comb
    begin
        d = q;
        d.pins1 = '{cs_n: chip_select_n_in, sclk: serial_clk_in, mosi: host_to_device_line_in};
        d.pins2 = q.pins1;
        d.sck_old = q.pins2.sclk;
        d.gen_reset = 1'b0;
        d.rd_strobe = 1'b0;
        d.en_old = q.status[14:0] & q.mask[14:0];
        d.status[HSP_PRG_BIT] = prg_ready_in;
        d.status[14:1] = q.status[14:1] | status_set_in;
        if (|newly)
        begin
            d.status[HSP_IRQ_BIT] = 1'b1; // RL14
        end
        d.irq_n = ~(q.status[HSP_IRQ_BIT] & q.mask[HSP_IRQ_BIT]); // RL16
        // Host writes to the mask only take hold at the poll tick
        if (q.timer == 15'd0)
        begin
            d.timer = 15'(LATENCY_CYCLES - 1);
            if (q.mask_pend)
            begin
                d.mask = q.mask_new; // RL7
                d.mask_pend = 1'b0;
            end
        end
        else
        begin
            d.timer = q.timer - 15'd1;
        end
        if (q.pend_v && buf_ready)
        begin
            d.pend_v = 1'b0;
        end
        if (!cs_low)
        begin
            d.phase = HSP_IDLE; // RL18
            d.bitcnt = 4'd0;
            d.oe_n = 1'b1; // RL11
        end
        else
        begin
            case (q.phase)
                HSP_IDLE:
                begin
                    d.phase = HSP_ADDR; // RL12
                    d.shreg = 16'h0000;
                end
                HSP_ADDR:
                begin
                    if (rise)
                    begin
                        d.shreg = {q.shreg[14:0], q.pins2.mosi}; // RL3
                        d.bitcnt = q.bitcnt + 4'd1;
                    end
                    if (addr_done)
                    begin
                        d.addr = addr_byte; // RL1
                        d.bitcnt = 4'd0;
                        d.shreg = 16'h0000;
                        d.nbytes = hsp_nbytes(addr_byte); // RL2
                        if (addr_byte < HSP_CMD_LIMIT)
                        begin
                            d.phase = HSP_DONE; // RL9
                            if (addr_byte == HSP_CMD_RESET)
                            begin
                                d.gen_reset = 1'b1; // RL9
                                d.status[14:1] = status_set_in;
                                d.status[HSP_IRQ_BIT] = 1'b0;
                                d.mask = HSP_MASK_RST;
                                d.mask_pend = 1'b0;
                                d.pend_v = 1'b0;
                            end
                        end
                        else if (addr_byte == HSP_ADDR_STATUS)
                        begin
                            d.tx = q.status;
                            d.oe_n = 1'b0;
                            d.phase = HSP_RDATA;
                            d.status[14:1] = status_set_in; // RL15
                            d.status[HSP_IRQ_BIT] = |newly; // RL15
                        end
                        else if (hsp_is_read(addr_byte))
                        begin
                            d.rd_addr = addr_byte;
                            d.rd_strobe = 1'b1;
                            d.phase = HSP_LOAD;
                        end
                        else
                        begin
                            d.phase = HSP_WDATA; // RL11
                        end
                    end
                end
                HSP_LOAD:
                begin
                    // Single-byte words go out of the top lane
                    d.tx = (q.nbytes == 2'd1) ? {rd_word_in[7:0], 8'h00} : rd_word_in; // RL17
                    d.oe_n = 1'b0;
                    d.phase = HSP_RDATA;
                end
                HSP_WDATA:
                begin
                    if (rise)
                    begin
                        d.shreg = {q.shreg[14:0], q.pins2.mosi}; // RL6
                        d.bitcnt = q.bitcnt + 4'd1;
                        if (q.bitcnt == 4'd7)
                        begin
                            d.bitcnt = 4'd0; // RL13
                            d.nbytes = q.nbytes - 2'd1;
                            if (q.nbytes == 2'd1)
                            begin
                                d.phase = HSP_DONE; // RL10
                                if (q.addr == HSP_ADDR_MASK)
                                begin
                                    d.mask_new = wdata;
                                    d.mask_pend = 1'b1;
                                end
                                else
                                begin
                                    d.pend = '{addr: q.addr, data: wdata}; // RL17
                                    d.pend_v = 1'b1;
                                end
                            end
                        end
                    end
                end
                HSP_RDATA:
                begin
                    if (fall)
                    begin
                        d.miso = q.tx[15]; // RL4
                    end
                    if (rise)
                    begin
                        d.tx = {q.tx[14:0], 1'b0}; // RL6
                        d.bitcnt = q.bitcnt + 4'd1;
                        if (q.bitcnt == 4'd7)
                        begin
                            d.bitcnt = 4'd0;
                            d.nbytes = q.nbytes - 2'd1;
                            if (q.nbytes == 2'd1)
                            begin
                                d.phase = HSP_DONE;
                            end
                        end
                    end
                end
                HSP_DONE:
                begin
                    d.bitcnt = 4'd0;
                end
                default:
                begin
                    d.phase = HSP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            q <= '0;
            q.pins1 <= 3'b111;
            q.pins2 <= 3'b111;
            // Old clock matches the preset synchroniser, so reset shows no false edge
            q.sck_old <= 1'b1;
            q.oe_n <= 1'b1;
            q.status <= HSP_STATUS_RST;
            q.mask <= HSP_MASK_RST;
            q.irq_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    hsp_pair_buf #(
        .WIDTH($bits(hsp_wr_t))
    ) u_buf (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(q.pend_v),
        .in_data_in(q.pend),
        .in_ready_out(buf_ready),
        .out_valid_out(wr_valid_out),
        .out_data_out(wr_word_out),
        .out_ready_in(wr_ready_in)
    );

    assign reply_data_out = q.miso;
    assign reply_data_oe_n_out = q.oe_n;
    assign interrupt_request_n_out = q.irq_n;
    assign interrupt_request_oe_n_out = q.irq_n;
    assign rd_addr_out = q.rd_addr;
    assign rd_strobe_out = q.rd_strobe;
    assign general_reset_out = q.gen_reset;

    sequence s_addr_done;
        addr_done;
    endsequence

    sequence s_cmd_reset;
        s_addr_done ##0 addr_byte == HSP_CMD_RESET;
    endsequence

    a_oe_when_deselected: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL11
        !cs_low |=> reply_data_oe_n_out)
        else $error("read line driven while deselected");
    a_write_keeps_hiz: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL11
        q.phase == HSP_WDATA |-> reply_data_oe_n_out)
        else $error("read line driven during a write");
    a_read_edge_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL4
        $changed(q.miso) |-> $past(fall) && $past(q.phase) == HSP_RDATA)
        else $error("read bit changed off a falling edge");
    // The eighth address bit clears the shifter, so only the first seven are watched
    a_sample_on_rise: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL3
        cs_low && rise && q.phase == HSP_ADDR && q.bitcnt != 4'd7
        |=> q.shreg[0] == $past(q.pins2.mosi))
        else $error("address bit not sampled on rising edge");
    a_cmd_reset_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL9
        s_cmd_reset |=> general_reset_out ##1 !general_reset_out ##0 q.phase != HSP_WDATA)
        else $error("general reset command not honoured");
    a_status_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL15
        s_addr_done ##0 addr_byte == HSP_ADDR_STATUS
        |=> q.status[14:1] == $past(status_set_in) && q.tx == $past(q.status))
        else $error("status read did not clear flags");
    a_irq_pin_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL16
        q.status[HSP_IRQ_BIT] && q.mask[HSP_IRQ_BIT] |=> !interrupt_request_n_out
        && !interrupt_request_oe_n_out)
        else $error("interrupt pin not driven");
    a_irq_needs_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL14
        $rose(q.status[HSP_IRQ_BIT]) |-> $past(|newly))
        else $error("interrupt flag raised without a masked change");
    a_abort_resync: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL18
        !cs_low |=> q.phase == HSP_IDLE && q.bitcnt == 4'd0)
        else $error("deselect did not abandon transaction");
    a_mask_at_poll: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL7
        $changed(q.mask) && !$past(general_reset_out) && !general_reset_out
        |-> $past(q.timer) == 15'd0)
        else $error("mask changed outside the poll tick");
endmodule
